/* hw/dlb_consts.svh */
// constants for the decorated load bit set/clear bridge
`ifndef DLB_CONSTS_SVH
`define DLB_CONSTS_SVH

// decorated address fields
`define DLB_TOP_BIT        31
`define DLB_REGION_HI      30
`define DLB_REGION_LO      29
`define DLB_OPC_HI         28
`define DLB_OPC_LO         26
`define DLB_BIT_HI         25
`define DLB_BIT_LO         21
`define DLB_OFS_HI         19
`define DLB_OFS_LO         0

// field codes
`define DLB_REGION_SRAM    2'h1
`define DLB_REGION_PERIPH  2'h2
`define DLB_OPC_CLEAR      3'h2
`define DLB_OPC_SET        3'h3

// region bases
`define DLB_SRAM_BASE      32'h2000_0000
`define DLB_PERIPH_BASE    32'h4000_0000

// bus encodings
`define DLB_SIZE_BYTE      3'h0
`define DLB_SIZE_HALF      3'h1
`define DLB_SIZE_WORD      3'h2
`define DLB_TRANS_IDLE     2'h0
`define DLB_TRANS_NONSEQ   2'h2
`define DLB_RESP_OKAY      1'h0

`endif

/* hw/dlb_pkg.sv */
// types for the decorated load bit set/clear bridge
package dlb_pkg;

  // address-phase attributes that travel together
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
  } dlb_aphase_s;

  // gray-coded sequence: idle -> read phase -> write phase
  typedef enum logic [1:0] {
    DLB_IDLE = 2'h0,
    DLB_RDP  = 2'h1,
    DLB_WDP  = 2'h3
  } dlb_state_e;

endpackage : dlb_pkg

/* hw/dlb_bitop.sv */
// one-hot mask, bit extract and set/clear of a read word
`timescale 1ns/100ps
`default_nettype none

module dlb_bitop
  import dlb_pkg::*;
#(
  parameter int DW = 32
) (
  // read data and selection
  input  wire logic [DW-1:0]         rdata,
  input  wire logic [$clog2(DW)-1:0] bit_idx,
  input  wire logic                  set_op,
  // results
  output logic                       bit_out,
  output logic [DW-1:0]              wdata
);

  logic [DW-1:0] mask;

  // one-hot mask, extracted bit, modified word
  assign mask    = {{(DW-1){1'b0}}, 1'b1} << bit_idx;
  assign bit_out = |(rdata & mask);
  assign wdata   = set_op ? (rdata | mask) : (rdata & ~mask);

endmodule : dlb_bitop

`default_nettype wire

/* hw/dlb_bridge.sv */
// inline bridge turning decorated loads into atomic bit set/clear
// Behaviour
// - clear request: return addressed bit, write location back with bit zero, atomically
// - set request: return addressed bit, write location back with bit one, atomically
// - returned data holds original bit in bit zero, all others zero
// - load access size picks byte, halfword or word container
// - address bits 30:29: 01 selects SRAM region, 10 selects peripherals
// - real address is region base plus low offset field
// - address bits 28:26 equal 010 mean load-and-clear of one bit
// - address bits 28:26 equal 011 mean load-and-set of one bit
// - bit position comes from address bits 25:21
// - don't-care address bits are ignored when decoding
// - first address phase reads undecorated address; next cycle re-issues it as write
// - clear: read, one-hot mask, extract bit, store read data AND not mask
// - set: read, one-hot mask, extract bit, store read data OR mask
// - core transfer stalls during the first data phase
// - slave wait states stretch the core transfer cycle for cycle
`timescale 1ns/100ps
`default_nettype none
`include "dlb_consts.svh"

module dlb_bridge
  import dlb_pkg::*;
#(
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  // core side, address phase
  input  wire logic [31:0]   up_haddr,
  input  wire logic [1:0]    up_htrans,
  input  wire logic          up_hwrite,
  input  wire logic [2:0]    up_hsize,
  input  wire logic [DW-1:0] up_hwdata,
  // core side, answer
  output logic [DW-1:0]      up_hrdata,
  output logic               up_hready,
  output logic               up_hresp,
  // memory side, address phase
  output logic [31:0]        dn_haddr,
  output logic [1:0]         dn_htrans,
  output logic               dn_hwrite,
  output logic [2:0]         dn_hsize,
  output logic [DW-1:0]      dn_hwdata,
  // memory side, answer
  input  wire logic [DW-1:0] dn_hrdata,
  input  wire logic          dn_hready,
  input  wire logic          dn_hresp
);

  localparam int BW = $clog2(DW);

  // bit index inside the bus word: lane offset plus position in container
  function automatic logic [BW-1:0] lane_bit(input logic [2:0] size,
                                             input logic [1:0] alow,
                                             input logic [4:0] pos);
    logic [BW-1:0] r;
    r = '0;
    unique case (size)
      `DLB_SIZE_BYTE: r = BW'({alow, pos[2:0]});
      `DLB_SIZE_HALF: r = BW'({alow[1], pos[3:0]});
      default:        r = BW'(pos);
    endcase
    return r;
  endfunction : lane_bit

  dlb_state_e    state_q;
  dlb_state_e    state_d;
  dlb_aphase_s   cap_q;
  logic          set_q;
  logic [BW-1:0] idx_q;
  logic          bit_q;
  logic [DW-1:0] wdata_q;

  dlb_aphase_s   up_ap;
  dlb_aphase_s   dn_ap;
  logic [1:0]    region;
  logic [2:0]    opcode;
  logic [4:0]    bit_pos;
  logic          region_ok;
  logic          opcode_ok;
  logic          is_deco;
  logic          start;
  logic [31:0]   real_addr;
  logic [31:0]   base_addr;
  logic          op_bit;
  logic [DW-1:0] op_wdata;

  // bundle the core address phase
  assign up_ap = '{addr: up_haddr, trans: up_htrans, write: up_hwrite, size: up_hsize};

  // decoration fields; marked don't-care bits are never looked at
  assign region    = up_haddr[`DLB_REGION_HI:`DLB_REGION_LO];
  assign opcode    = up_haddr[`DLB_OPC_HI:`DLB_OPC_LO];
  assign bit_pos   = up_haddr[`DLB_BIT_HI:`DLB_BIT_LO];
  assign region_ok = (region == `DLB_REGION_SRAM) || (region == `DLB_REGION_PERIPH);
  assign opcode_ok = (opcode == `DLB_OPC_CLEAR) || (opcode == `DLB_OPC_SET);
  assign is_deco   = !up_haddr[`DLB_TOP_BIT] && region_ok && opcode_ok;

  // a decorated read is taken only when the core's address phase completes
  assign start = up_hready && up_htrans[1] && !up_hwrite && is_deco;

  // strip decoration: region base plus the low offset
  assign base_addr = (region == `DLB_REGION_SRAM) ? `DLB_SRAM_BASE : `DLB_PERIPH_BASE;
  assign real_addr = base_addr | {12'h000, up_haddr[`DLB_OFS_HI:`DLB_OFS_LO]};

  // memory-side address phase: live, stripped, or recirculated as a write
  always_comb
  begin
    dn_ap = up_ap;
    if (state_q == DLB_RDP)
    begin
      dn_ap       = cap_q;
      dn_ap.write = 1'b1;
    end
    else if (start)
    begin
      dn_ap.addr = real_addr;
    end
  end

  assign dn_haddr  = dn_ap.addr;
  assign dn_htrans = dn_ap.trans;
  assign dn_hwrite = dn_ap.write;
  assign dn_hsize  = dn_ap.size;

  // write data: registered modified word in the second data phase
  assign dn_hwdata = (state_q == DLB_WDP) ? wdata_q : up_hwdata;

  // read data: right-justified, zero-filled original bit
  assign up_hrdata = (state_q == DLB_WDP) ? {{(DW-1){1'b0}}, bit_q} : dn_hrdata;

  // core stalls through the read phase; slave waits pass straight through
  assign up_hready = (state_q == DLB_RDP) ? 1'b0 : dn_hready;
  // error responses pass through except in the read phase, which answers OKAY; a failed read still completes the write
  assign up_hresp  = (state_q == DLB_RDP) ? `DLB_RESP_OKAY : dn_hresp;

  // mask, extract and modify on the live read data
  dlb_bitop #(
    .DW      (DW)
  ) u_bitop (
    .rdata   (dn_hrdata),
    .bit_idx (idx_q),
    .set_op  (set_q),
    .bit_out (op_bit),
    .wdata   (op_wdata)
  );

  // sequence: read phase waits for the slave, write phase likewise
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DLB_IDLE:
      begin
        if (start)
          state_d = DLB_RDP;
      end
      DLB_RDP:
      begin
        if (dn_hready)
          state_d = DLB_WDP;
      end
      DLB_WDP:
      begin
        if (dn_hready)
          state_d = start ? DLB_RDP : DLB_IDLE;
      end
      default: state_d = DLB_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= DLB_IDLE;
    else
      state_q <= state_d;
  end

  // capture stripped address and attributes at the first address phase
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cap_q <= '0;
      set_q <= 1'b0;
      idx_q <= '0;
    end
    else if (start)
    begin
      cap_q      <= up_ap;
      cap_q.addr <= real_addr;
      set_q      <= (opcode == `DLB_OPC_SET);
      idx_q      <= lane_bit(up_hsize, up_haddr[1:0], bit_pos);
    end
  end

  // hold original bit and modified word once the read data is valid
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bit_q   <= 1'b0;
      wdata_q <= '0;
    end
    else if (state_q == DLB_RDP && dn_hready)
    begin
      bit_q   <= op_bit;
      wdata_q <= op_wdata;
    end
  end

endmodule : dlb_bridge

`default_nettype wire

/* bench/dlb_mem_model.sv */
// memory slave model on the bridge's far side
`timescale 1ns/100ps
`default_nettype none
module dlb_mem_model (
  // clock, reset, wait count
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  waits,
  // request
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  // answer
  output logic [31:0]      hrdata,
  output logic             hready
);
  logic [31:0] m [16];
  logic [3:0]  a_q;
  logic        v_q;
  logic        w_q;
  logic [1:0]  n_q;
  // idle bus is always ready
  assign hready = !v_q || n_q == 2'h0;
  // inverse outside a read answer, so stale data never passes
  assign hrdata = v_q && !w_q && hready ? m[a_q] : ~m[a_q];
  // pipelined slave; not always_ff since the bench preloads m
  always @(posedge clk)
    if (rst)
      v_q <= 1'b0;
    else if (hready)
    begin
      if (v_q && w_q) m[a_q] <= hwdata;
      v_q <= htrans[1];
      w_q <= hwrite;
      a_q <= haddr[5:2];
      n_q <= waits;
    end
    else
      n_q <= n_q - 2'h1;
endmodule : dlb_mem_model
`default_nettype wire

/* bench/dlb_bridge_asserts.sv */
// port assertions for the bridge
`timescale 1ns/100ps
`default_nettype none
`include "dlb_consts.svh"
module dlb_bridge_asserts
  import dlb_pkg::*;
#(
  parameter int DW = 32
) (
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          sys_rst,
  // core side
  input wire logic [31:0]   up_haddr,
  input wire logic [1:0]    up_htrans,
  input wire logic          up_hwrite,
  input wire logic [2:0]    up_hsize,
  input wire logic [DW-1:0] up_hrdata,
  input wire logic          up_hready,
  input wire logic          up_hresp,
  // memory side
  input wire logic [31:0]   dn_haddr,
  input wire logic [1:0]    dn_htrans,
  input wire logic          dn_hwrite,
  input wire logic [DW-1:0] dn_hwdata,
  input wire logic [DW-1:0] dn_hrdata,
  input wire logic          dn_hready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // decorated bit load taken this edge
  wire sr = up_haddr[30:29] == `DLB_REGION_SRAM;
  wire rg = sr || up_haddr[30:29] == `DLB_REGION_PERIPH;
  wire dec = up_hready && up_htrans[1] && !up_hwrite && !up_haddr[31] && rg && up_haddr[28:27] == 2'h1;
  wire [31:0] real_a = (sr ? `DLB_SRAM_BASE : `DLB_PERIPH_BASE) | {12'h000, up_haddr[19:0]};
  logic [4:0] idx_q;
  logic       set_q;
  // decoration kept for data phase checks
  always_ff @(posedge sys_clk)
    if (dec)
    begin
      idx_q <= up_haddr[25:21];
      set_q <= up_haddr[26];
    end
  sequence rd_ok; dec ##1 dn_hready; endsequence
  sequence wd_rd; dec && up_hsize == `DLB_SIZE_WORD ##1 dn_hready; endsequence
  chk_strip_addr: assert property (dec |-> dn_haddr == real_a && !dn_hwrite)
    else $error("stripped read address wrong");
  chk_write_reissue: assert property (dec |=> dn_hwrite && dn_haddr == $past(dn_haddr)
    && dn_htrans == $past(up_htrans)) else $error("write not reissued");
  chk_core_stall: assert property (dec |=> !up_hready && !up_hresp)
    else $error("core not stalled");
  chk_ret_zero: assert property (rd_ok |=> up_hrdata[DW-1:1] == '0)
    else $error("upper return bits set");
  chk_ret_bit: assert property (wd_rd |=> up_hrdata[0] == $past(dn_hrdata[idx_q]))
    else $error("returned bit wrong");
  chk_wdata_mod: assert property (wd_rd |=> dn_hwdata == (set_q ? $past(dn_hrdata) | (DW'(1) << idx_q)
    : $past(dn_hrdata) & ~(DW'(1) << idx_q))) else $error("write data wrong");
  chk_read_wait: assert property (dec ##1 !dn_hready ##1 dn_hready |-> !up_hready)
    else $error("read wait not passed");
  chk_write_wait: assert property (rd_ok ##1 1'b1 |-> up_hready == dn_hready)
    else $error("write wait not passed");
endmodule : dlb_bridge_asserts
bind dlb_bridge dlb_bridge_asserts #(.DW(DW)) u_chk (.sys_clk, .sys_rst, .up_haddr, .up_htrans, .up_hwrite,
  .up_hsize, .up_hrdata, .up_hready, .up_hresp, .dn_haddr, .dn_htrans, .dn_hwrite, .dn_hwdata, .dn_hrdata, .dn_hready);
`default_nettype wire

/* bench/tb.sv */
// testbench for the decorated load bridge
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        sys_clk = 0, sys_rst = 1, up_hwrite = 0, up_hready, up_hresp, dn_hwrite, dn_hready;
  logic [31:0] up_haddr = '0, up_hwdata = '0, up_hrdata, dn_haddr, dn_hwdata, dn_hrdata;
  logic [1:0]  up_htrans = '0, dn_htrans, waits = '0;
  logic [2:0]  up_hsize = '0, dn_hsize;
  int          err_count = 0, samples_checked = 0, cyc = 0;
  dlb_bridge dut (.sys_clk, .sys_rst, .up_haddr, .up_htrans, .up_hwrite, .up_hsize, .up_hwdata,
    .up_hrdata, .up_hready, .up_hresp, .dn_haddr, .dn_htrans, .dn_hwrite, .dn_hsize, .dn_hwdata,
    .dn_hrdata, .dn_hready, .dn_hresp(1'b0));
  dlb_mem_model mem (.clk(sys_clk), .rst(sys_rst), .waits, .haddr(dn_haddr), .htrans(dn_htrans),
    .hwrite(dn_hwrite), .hwdata(dn_hwdata), .hrdata(dn_hrdata), .hready(dn_hready));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // far beyond the longest run; a hang ends here
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      test_done();
    end
  end
  // one decorated load, judged on latency, returned bit and memory
  task automatic bit_op(input logic [1:0] rg, input logic set, input logic [2:0] sz, input logic [4:0] b,
                        input logic [3:0] w, input logic [1:0] ln, input logic [1:0] ws);
    logic [31:0] old;
    logic [4:0]  ix;
    int          n;
    ln = sz == 3'h2 ? 2'h0 : sz == 3'h1 ? {ln[1], 1'b0} : ln;
    old = mem.m[w];
    ix = sz == 3'h2 ? b : sz == 3'h1 ? {ln[1], b[3:0]} : {ln, b[2:0]};
    waits = ws;
    // bit 20 set: a don't-care bit must not matter
    up_haddr = {1'b0, rg, 2'h1, set, b, 1'b1, 14'h0, w, ln};
    up_hsize = sz;
    up_htrans = 2'h2;
    @(posedge sys_clk);
    #1 up_htrans = 2'h0;
    n = 1;
    @(negedge sys_clk);
    // read phase: the write address phase carries the load's size
    check(dn_hwrite, 1'b1);
    check(dn_hsize, sz);
    while (up_hready !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge sys_clk);
    end
    check(n, 2 + 2 * ws);
    check(up_hrdata, {31'h0, old[ix]});
    check(up_hresp, 1'b0);
    repeat (2) @(posedge sys_clk);
    // off the edge, so the next call never races the sampling edge
    #1 check(mem.m[w], set ? old | (32'h1 << ix) : old & ~(32'h1 << ix));
  endtask : bit_op
  // plain transfers pass straight through, decorated-looking writes too
  task automatic pass_thru(input logic wr, input logic [3:0] w, input logic [31:0] d);
    logic [31:0] old;
    old = mem.m[w];
    waits = 2'h0;
    up_haddr = {1'b0, 2'h1, wr ? 3'h2 : 3'h1, 20'h0, w, 2'h0};
    up_hwrite = wr;
    up_hsize = 3'h2;
    up_htrans = 2'h2;
    #1 check(dn_haddr, up_haddr);
    check(dn_hwrite, wr);
    @(posedge sys_clk);
    #1 up_htrans = 2'h0;
    up_hwrite = 1'b0;
    up_hwdata = d;
    @(negedge sys_clk);
    check(up_hready, 1'b1);
    if (!wr)
      check(up_hrdata, old);
    else
      check(dn_hwdata, d);
    @(posedge sys_clk);
    #1 check(mem.m[w], wr ? d : old);
  endtask : pass_thru
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem.m[i] = 32'hA5C3_0F96 ^ (i * 32'h1111_1111);
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 0;
    // both opcodes, all sizes and both regions; repeat so bits are seen set
    for (int k = 0; k < 24; k++)
      bit_op(k[1] ? 2'h1 : 2'h2, k[0], 3'(k % 3), 5'(7 * (k / 2) + 3), 4'(k / 2), {k[3], 1'b0}, 2'h0);
    pass_thru(1'b0, 4'h5, 32'h0);
    pass_thru(1'b1, 4'h6, 32'h1234_5678);
    bit_op(2'h1, 1'b1, 3'h2, 5'h1F, 4'h3, 2'h0, 2'h2);
    bit_op(2'h2, 1'b0, 3'h0, 5'h1E, 4'h3, 2'h3, 2'h1);
    test_done();
  end
endmodule : tb
`default_nettype wire
